// ---- src/sbci_issue_ctrl.sv ----
// Issue timing and control for stores, multiple transfers, branches and calls
`timescale 1ns/10ps
`include "sbci_regs.svh"
module sbci_issue_ctrl
	import sbci_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// Issue request
	input wire logic issue_valid_in,
	input wire sbci_op_t op_in,
	input wire sbci_mode_t mode_in,
	input wire sbci_size_t size_in,
	input wire logic [4:0] reg_count_in,
	input wire logic pc_in_list_in,
	input wire logic writeback_in,
	input wire logic cond_ok_in,
	// Core state
	input wire logic [3:0] core_rev_in,
	input wire logic debug_en_in,
	input wire logic irq_pending_in,
	// Memory side
	input wire logic system_bus_sel_in,
	input wire logic system_bus_ready_in,
	// Operands
	input wire logic [31:0] src_a_in,
	input wire logic [31:0] src_b_in,
	input wire logic [31:0] ret_addr_in,
	// Issue status
	output logic busy_out,
	output logic done_out,
	output logic flush_out,
	output logic abort_out,
	output logic illegal_out,
	output logic r12_test_out,
	// Register updates
	output logic link_wr_out,
	output logic [31:0] link_data_out,
	output logic dbg_ret_wr_out,
	output logic [31:0] dbg_ret_data_out,
	output logic rv_wr_out,
	output logic [31:0] rv_data_out,
	// Memory writes
	output logic mem_wr_out,
	output logic [31:0] mem_data_out,
	output sbci_size_t mem_size_out,
	output logic mem_word_out
);

	localparam sbci_state_t SBCI_S_RST = '0;

	sbci_state_t s_reg;
	sbci_state_t s_next;
	logic [31:0] fmt_data;
	logic [5:0] lat;
	logic is_multi;
	logic is_flow;
	logic is_write;
	logic bad_rev;
	logic accept;

	////////////////////////////////////////////////////////////////////////
	// Latency of one instruction from its form and outcome

	function automatic logic [5:0] sbci_lat(input sbci_op_t op, input sbci_mode_t mode,
		input logic [4:0] n, input logic p, input logic wb, input logic sys,
		input logic cond, input logic dbg);
		logic [5:0] n1;
		logic [5:0] n2;
		logic [5:0] pp;
		logic [5:0] l;
		n1 = {1'b0, n};
		n2 = {n, 1'b0};
		pp = {5'h00, p};
		l = `SBCI_LAT_ONE;
		case (op)
			SBCI_OP_LD_SP, SBCI_OP_ST_SP: begin
				l = `SBCI_LAT_ONE;
			end
			SBCI_OP_BYTE_STORE, SBCI_OP_HALF_STORE, SBCI_OP_WORD_STORE: begin
				l = (mode == SBCI_MODE_INDEXED) ? `SBCI_LAT_INDEXED : `SBCI_LAT_ONE;
			end
			SBCI_OP_COND_STORE, SBCI_OP_SWAP_STORE: begin
				l = `SBCI_LAT_ONE;
			end
			SBCI_OP_DOUBLE_STORE: begin
				l = (mode == SBCI_MODE_INDEXED) ? `SBCI_LAT_DBL_INDEXED : `SBCI_LAT_DBL;
			end
			SBCI_OP_STCOND: begin
				l = cond ? `SBCI_LAT_STCOND_OK : `SBCI_LAT_STCOND_FAIL;
			end
			SBCI_OP_COMBINE: begin
				l = `SBCI_LAT_COMBINE;
			end
			SBCI_OP_LDM: begin
				// The p term is the return value test and flow change
				if (sys) begin
					l = wb ? (`SBCI_MULTI_BASE1 + n2) : (`SBCI_MULTI_BASE1 + n2 + pp);
				end else begin
					// Writeback form hides the PC change in its writeback cycle
					l = wb ? (`SBCI_MULTI_BASE2 + n1) : (`SBCI_MULTI_BASE1 + n1 + pp);
				end
			end
			SBCI_OP_LDMTS: begin
				if (sys) begin
					l = `SBCI_MULTI_BASE1 + n2;
				end else begin
					l = wb ? (`SBCI_MULTI_BASE2 + n1) : (`SBCI_MULTI_BASE1 + n1);
				end
			end
			SBCI_OP_POPM: begin
				l = sys ? (`SBCI_MULTI_BASE1 + n2) : (`SBCI_MULTI_BASE2 + n1);
			end
			SBCI_OP_PUSHM: begin
				l = sys ? (`SBCI_MULTI_BASE3 + n1) : (`SBCI_MULTI_BASE2 + n1);
			end
			SBCI_OP_STM, SBCI_OP_STMTS: begin
				if (wb) begin
					l = sys ? (`SBCI_MULTI_BASE3 + n1) : (`SBCI_MULTI_BASE2 + n1);
				end else begin
					l = sys ? (`SBCI_MULTI_BASE2 + n1) : (`SBCI_MULTI_BASE1 + n1);
				end
			end
			SBCI_OP_BRANCH, SBCI_OP_RET: begin
				l = cond ? (`SBCI_LAT_ONE + `SBCI_TAKEN_PEN) : `SBCI_LAT_ONE;
			end
			SBCI_OP_RJMP: begin
				l = `SBCI_LAT_ONE + `SBCI_TAKEN_PEN;
			end
			SBCI_OP_CALL: begin
				l = `SBCI_LAT_CALL;
			end
			SBCI_OP_SCALL: begin
				l = `SBCI_LAT_SCALL;
			end
			SBCI_OP_SSCALL: begin
				l = `SBCI_LAT_SSCALL;
			end
			SBCI_OP_BKPT: begin
				l = dbg ? `SBCI_LAT_BKPT : `SBCI_LAT_ONE;
			end
			default: begin
				l = `SBCI_LAT_ONE;
			end
		endcase
		return l;
	endfunction

	sbci_store_fmt u_fmt (
		.op_in(op_in),
		.size_in(size_in),
		.src_a_in(src_a_in),
		.src_b_in(src_b_in),
		.data_out(fmt_data)
	);

	////////////////////////////////////////////////////////////////////////
	// Decode of the request

	always_comb begin
		is_multi = (op_in == SBCI_OP_LDM) || (op_in == SBCI_OP_LDMTS) ||
			(op_in == SBCI_OP_POPM) || (op_in == SBCI_OP_PUSHM) ||
			(op_in == SBCI_OP_STM) || (op_in == SBCI_OP_STMTS);
		bad_rev = ((op_in == SBCI_OP_COND_STORE) && (core_rev_in < `SBCI_REV_COND)) ||
			((op_in == SBCI_OP_SSCALL) && (core_rev_in < `SBCI_REV_SECURE));
		is_write = (op_in == SBCI_OP_ST_SP) || (op_in == SBCI_OP_BYTE_STORE) ||
			(op_in == SBCI_OP_HALF_STORE) || (op_in == SBCI_OP_WORD_STORE) ||
			(op_in == SBCI_OP_DOUBLE_STORE) || (op_in == SBCI_OP_COMBINE) ||
			(op_in == SBCI_OP_SWAP_STORE) ||
			(((op_in == SBCI_OP_COND_STORE) || (op_in == SBCI_OP_STCOND)) && cond_ok_in);
		is_flow = ((op_in == SBCI_OP_BRANCH) && cond_ok_in) || (op_in == SBCI_OP_RJMP) ||
			((op_in == SBCI_OP_RET) && cond_ok_in) || (op_in == SBCI_OP_CALL) ||
			(op_in == SBCI_OP_SCALL) || (op_in == SBCI_OP_SSCALL) ||
			((op_in == SBCI_OP_BKPT) && debug_en_in) ||
			(((op_in == SBCI_OP_LDM) || (op_in == SBCI_OP_POPM)) && pc_in_list_in);
		lat = bad_rev ? `SBCI_LAT_ONE : sbci_lat(op_in, mode_in, reg_count_in, pc_in_list_in,
			writeback_in, system_bus_sel_in, cond_ok_in, debug_en_in);
		accept = issue_valid_in && (s_reg.state == SBCI_ST_IDLE) &&
			!(is_multi && irq_pending_in);
	end

	////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		s_next = s_reg;
		s_next.done = 1'b0;
		s_next.flush = 1'b0;
		s_next.abort = 1'b0;
		s_next.illegal = 1'b0;
		s_next.r12_test = 1'b0;
		s_next.link_wr = 1'b0;
		s_next.dbg_wr = 1'b0;
		s_next.rv_wr = 1'b0;
		s_next.mem_wr = 1'b0;
		case (s_reg.state)
			SBCI_ST_IDLE: begin
				if (issue_valid_in && is_multi && irq_pending_in) begin
					s_next.abort = 1'b1;
				end else if (issue_valid_in && bad_rev) begin
					// Unsupported form on this revision retires at once with illegal set
					s_next.illegal = 1'b1;
					s_next.done = 1'b1;
				end else if (issue_valid_in) begin
					s_next.multi = is_multi;
					s_next.sys = system_bus_sel_in;
					s_next.mem_word = is_multi;
					s_next.flush_pend = is_flow;
					s_next.mem_wr = is_write;
					s_next.mem_data = fmt_data;
					s_next.wdata2 = src_b_in;
					s_next.dbl_pend = (op_in == SBCI_OP_DOUBLE_STORE);
					if ((op_in == SBCI_OP_BYTE_STORE) ||
						((op_in == SBCI_OP_COND_STORE) && (size_in == SBCI_SZ_BYTE))) begin
						s_next.mem_size = SBCI_SZ_BYTE;
					end else if ((op_in == SBCI_OP_HALF_STORE) ||
						((op_in != SBCI_OP_COMBINE) && (size_in == SBCI_SZ_HALF) &&
						((op_in == SBCI_OP_COND_STORE) || (op_in == SBCI_OP_SWAP_STORE)))) begin
						s_next.mem_size = SBCI_SZ_HALF;
					end else begin
						s_next.mem_size = SBCI_SZ_WORD;
					end
					s_next.link_wr = (op_in == SBCI_OP_CALL) || (op_in == SBCI_OP_SCALL) ||
						(op_in == SBCI_OP_SSCALL);
					s_next.link_data = ret_addr_in;
					s_next.dbg_wr = (op_in == SBCI_OP_BKPT) && debug_en_in;
					s_next.dbg_data = ret_addr_in;
					s_next.rv_wr = (op_in == SBCI_OP_RET);
					s_next.rv_data = src_a_in;
					s_next.r12_test = (((op_in == SBCI_OP_LDM) || (op_in == SBCI_OP_POPM)) &&
						pc_in_list_in) || (op_in == SBCI_OP_RET);
					if (lat == `SBCI_LAT_ONE) begin
						s_next.done = 1'b1;
						s_next.flush = is_flow;
						s_next.mem_word = 1'b0;
					end else begin
						s_next.state = SBCI_ST_RUN;
						s_next.busy = 1'b1;
						s_next.cnt = lat - `SBCI_LAT_ONE;
					end
				end
			end
			SBCI_ST_RUN: begin
				if (s_reg.dbl_pend) begin
					s_next.mem_wr = 1'b1;
					s_next.mem_data = s_reg.wdata2;
					s_next.mem_size = SBCI_SZ_WORD;
					s_next.dbl_pend = 1'b0;
				end
				if (s_reg.multi && irq_pending_in) begin
					// Bounded interrupt latency wins over finishing the list
					s_next.abort = 1'b1;
					s_next.state = SBCI_ST_IDLE;
					s_next.busy = 1'b0;
					s_next.mem_word = 1'b0;
					s_next.flush_pend = 1'b0;
				end else if (!(s_reg.multi && s_reg.sys && !system_bus_ready_in)) begin
					if (s_reg.cnt == `SBCI_LAT_ONE) begin
						s_next.state = SBCI_ST_IDLE;
						s_next.busy = 1'b0;
						s_next.done = 1'b1;
						s_next.flush = s_reg.flush_pend;
						s_next.mem_word = 1'b0;
					end else begin
						s_next.cnt = s_reg.cnt - `SBCI_LAT_ONE;
					end
				end
			end
			default: begin
				s_next = SBCI_S_RST;
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			s_reg <= SBCI_S_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	assign busy_out = s_reg.busy;
	assign done_out = s_reg.done;
	assign flush_out = s_reg.flush;
	assign abort_out = s_reg.abort;
	assign illegal_out = s_reg.illegal;
	assign r12_test_out = s_reg.r12_test;
	assign link_wr_out = s_reg.link_wr;
	assign link_data_out = s_reg.link_data;
	assign dbg_ret_wr_out = s_reg.dbg_wr;
	assign dbg_ret_data_out = s_reg.dbg_data;
	assign rv_wr_out = s_reg.rv_wr;
	assign rv_data_out = s_reg.rv_data;
	assign mem_wr_out = s_reg.mem_wr;
	assign mem_data_out = s_reg.mem_data;
	assign mem_size_out = s_reg.mem_size;
	assign mem_word_out = s_reg.mem_word;

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);

	property p_sp_one;
		accept && (op_in == SBCI_OP_ST_SP) |=> done_out && !busy_out;
	endproperty
	a_sp_one: assert property (p_sp_one) else $error("sp store not one cycle");

	property p_idx_store;
		accept && (op_in == SBCI_OP_WORD_STORE) && (mode_in == SBCI_MODE_INDEXED)
			|=> busy_out && !done_out ##1 done_out;
	endproperty
	a_idx_store: assert property (p_idx_store) else $error("indexed store not two");

	property p_cond_gate;
		accept && (op_in == SBCI_OP_COND_STORE) && !cond_ok_in |=> !mem_wr_out;
	endproperty
	a_cond_gate: assert property (p_cond_gate) else $error("failed cond store wrote");

	property p_double;
		accept && (op_in == SBCI_OP_DOUBLE_STORE) && (mode_in != SBCI_MODE_INDEXED)
			|=> mem_wr_out && !done_out ##1 mem_wr_out && done_out;
	endproperty
	a_double: assert property (p_double) else $error("double store timing wrong");

	property p_swap;
		accept && (op_in == SBCI_OP_SWAP_STORE) && (size_in == SBCI_SZ_WORD)
			|=> mem_data_out == {$past(src_a_in[7:0]), $past(src_a_in[15:8]),
			$past(src_a_in[23:16]), $past(src_a_in[31:24])};
	endproperty
	a_swap: assert property (p_swap) else $error("swap store data wrong");

	property p_push_internal_ram;
		accept && (op_in == SBCI_OP_PUSHM) && !system_bus_sel_in && (reg_count_in == 5'h03)
			&& !irq_pending_in ##1 !irq_pending_in [*4] |-> ##1 done_out;
	endproperty
	a_push_internal_ram: assert property (p_push_internal_ram) else $error("push not 2+n");

	property p_irq_abort;
		busy_out && mem_word_out && irq_pending_in |=> abort_out && !busy_out && !done_out;
	endproperty
	a_irq_abort: assert property (p_irq_abort) else $error("multi not aborted");

	property p_taken;
		accept && (op_in == SBCI_OP_BRANCH) && cond_ok_in
			|=> busy_out [*2] ##1 (done_out && flush_out);
	endproperty
	a_taken: assert property (p_taken) else $error("taken branch not three");

	property p_untaken;
		accept && (op_in == SBCI_OP_BRANCH) && !cond_ok_in |=> done_out && !flush_out;
	endproperty
	a_untaken: assert property (p_untaken) else $error("untaken branch flushed");

	property p_call;
		accept && (op_in == SBCI_OP_CALL) |=> link_wr_out ##3 (done_out && flush_out);
	endproperty
	a_call: assert property (p_call) else $error("call not four cycles");

	property p_bkpt;
		accept && (op_in == SBCI_OP_BKPT) && debug_en_in |=> dbg_ret_wr_out && !link_wr_out;
	endproperty
	a_bkpt: assert property (p_bkpt) else $error("breakpoint wrote link");

	c_taken: cover property (done_out && flush_out);
	c_abort: cover property (busy_out && mem_word_out && irq_pending_in);
	c_stall: cover property (busy_out && mem_word_out && !system_bus_ready_in);

endmodule

// ---- src/sbci_pkg.sv ----
// Types for store, branch and call issue timing
package sbci_pkg;

	typedef enum logic [4:0] {
		SBCI_OP_NOP = 5'h00,
		SBCI_OP_LD_SP = 5'h01,
		SBCI_OP_ST_SP = 5'h02,
		SBCI_OP_BYTE_STORE = 5'h03,
		SBCI_OP_HALF_STORE = 5'h04,
		SBCI_OP_WORD_STORE = 5'h05,
		SBCI_OP_COND_STORE = 5'h06,
		SBCI_OP_DOUBLE_STORE = 5'h07,
		SBCI_OP_STCOND = 5'h08,
		SBCI_OP_COMBINE = 5'h09,
		SBCI_OP_SWAP_STORE = 5'h0A,
		SBCI_OP_LDM = 5'h0B,
		SBCI_OP_LDMTS = 5'h0C,
		SBCI_OP_POPM = 5'h0D,
		SBCI_OP_PUSHM = 5'h0E,
		SBCI_OP_STM = 5'h0F,
		SBCI_OP_STMTS = 5'h10,
		SBCI_OP_BRANCH = 5'h11,
		SBCI_OP_RJMP = 5'h12,
		SBCI_OP_RET = 5'h13,
		SBCI_OP_CALL = 5'h14,
		SBCI_OP_SCALL = 5'h15,
		SBCI_OP_SSCALL = 5'h16,
		SBCI_OP_BKPT = 5'h17
	} sbci_op_t;

	typedef enum logic [2:0] {
		SBCI_MODE_POSTINC = 3'h0,
		SBCI_MODE_PREDEC = 3'h1,
		SBCI_MODE_DISP = 3'h2,
		SBCI_MODE_INDEXED = 3'h3,
		SBCI_MODE_PLAIN = 3'h4
	} sbci_mode_t;

	typedef enum logic [1:0] {
		SBCI_SZ_BYTE = 2'h0,
		SBCI_SZ_HALF = 2'h1,
		SBCI_SZ_WORD = 2'h2
	} sbci_size_t;

	typedef enum logic [1:0] {
		SBCI_ST_IDLE = 2'h0,
		SBCI_ST_RUN = 2'h1
	} sbci_fsm_t;

	typedef struct packed {
		sbci_fsm_t state;
		logic [5:0] cnt;
		logic multi;
		logic sys;
		logic flush_pend;
		logic dbl_pend;
		logic [31:0] wdata2;
		logic busy;
		logic done;
		logic flush;
		logic abort;
		logic illegal;
		logic r12_test;
		logic link_wr;
		logic [31:0] link_data;
		logic dbg_wr;
		logic [31:0] dbg_data;
		logic rv_wr;
		logic [31:0] rv_data;
		logic mem_wr;
		logic [31:0] mem_data;
		sbci_size_t mem_size;
		logic mem_word;
	} sbci_state_t;

endpackage

// ---- src/sbci_regs.svh ----
// Constants for store, branch and call issue timing
`ifndef SBCI_REGS_SVH
`define SBCI_REGS_SVH

// Issue latencies in cycles
`define SBCI_LAT_ONE 6'h01
`define SBCI_LAT_INDEXED 6'h02
`define SBCI_LAT_DBL 6'h02
`define SBCI_LAT_DBL_INDEXED 6'h03
`define SBCI_LAT_STCOND_FAIL 6'h02
`define SBCI_LAT_STCOND_OK 6'h03
`define SBCI_LAT_COMBINE 6'h02
`define SBCI_LAT_CALL 6'h04
`define SBCI_LAT_SCALL 6'h06
`define SBCI_LAT_SSCALL 6'h05
`define SBCI_LAT_BKPT 6'h03
`define SBCI_TAKEN_PEN 6'h02

// Fixed parts of the multiple-transfer formulas
`define SBCI_MULTI_BASE1 6'h01
`define SBCI_MULTI_BASE2 6'h02
`define SBCI_MULTI_BASE3 6'h03

// Core revision thresholds
`define SBCI_REV_COND 4'h2
`define SBCI_REV_SECURE 4'h3

`endif

// ---- src/sbci_store_fmt.sv ----
// Store data formatting: byte swap and halfword combine
`timescale 1ns/10ps
module sbci_store_fmt
	import sbci_pkg::*;
(
	// Request
	input wire sbci_op_t op_in,
	input wire sbci_size_t size_in,
	// Source values
	input wire logic [31:0] src_a_in,
	input wire logic [31:0] src_b_in,
	// Formatted data
	output logic [31:0] data_out
);

	logic [31:0] swap_w;
	genvar i;

	generate
		for (i = 0; i < 4; i = i + 1) begin : g_rev
			assign swap_w[8*i +: 8] = src_a_in[8*(3-i) +: 8];
		end
	endgenerate

	always_comb begin
		data_out = src_a_in;
		if (op_in == SBCI_OP_SWAP_STORE) begin
			// Halfword swap only reverses the low two bytes
			if (size_in == SBCI_SZ_HALF) begin
				data_out = {16'h0000, src_a_in[7:0], src_a_in[15:8]};
			end else begin
				data_out = swap_w;
			end
		end else if (op_in == SBCI_OP_COMBINE) begin
			data_out = {src_a_in[15:0], src_b_in[15:0]};
		end
	end

endmodule

// ---- verification/sbci_mem_model.sv ----
// Memory side model: system bus slave with programmable wait states
`timescale 1ns/10ps
module sbci_mem_model
	import sbci_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// Core side
	input wire logic mem_word_in,
	input wire logic [3:0] wait_cycles_in,
	// Slave answer
	output logic ready_out
);
	logic [3:0] wait_reg;
	// Wait states once at the start of each multiple transfer, so the added count is exact
	always_ff @(posedge clk_in) begin
		if (!rst_b_in || !mem_word_in) begin
			wait_reg <= 4'h0;
		end else if (wait_reg != 4'hF) begin
			wait_reg <= wait_reg + 4'h1;
		end
	end
	assign ready_out = !(mem_word_in && (wait_reg < wait_cycles_in));
endmodule

// ---- verification/store_branch_call_issue_timing_bench.sv ----
// Testbench for the issue timing and control block
`timescale 1ns/10ps
module store_branch_call_issue_timing_bench
	import sbci_pkg::*;
;
	logic clk = 1'b0, rst_b = 1'b0, valid = 1'b0, p = 1'b0, wb = 1'b0, cond = 1'b0;
	logic dbg = 1'b0, irq = 1'b0, sys = 1'b0, ready;
	logic busy, done, flush, abort, illegal, r12, link_wr, dbg_wr, rv_wr, mem_wr, mem_word;
	logic [3:0] rev = 4'h2, waits = 4'h0;
	logic [4:0] n = 5'h00;
	logic [31:0] src_a = 32'h11223344, src_b = 32'hA5B6C7D8, ret = 32'h00001F00;
	logic [31:0] link_data, dbg_data, rv_data, mem_data, last_data, first_data;
	logic [8:0] seen;
	sbci_op_t op = SBCI_OP_NOP;
	sbci_mode_t mode = SBCI_MODE_DISP;
	sbci_size_t size = SBCI_SZ_WORD;
	sbci_size_t mem_size;
	int miscompares = 0, checks_done = 0, n_wr, irq_at = 0;

	always #5 clk = ~clk;

	sbci_issue_ctrl DUT (.clk_in(clk), .rst_b_in(rst_b), .issue_valid_in(valid), .op_in(op),
		.mode_in(mode), .size_in(size), .reg_count_in(n), .pc_in_list_in(p),
		.writeback_in(wb), .cond_ok_in(cond), .core_rev_in(rev), .debug_en_in(dbg),
		.irq_pending_in(irq), .system_bus_sel_in(sys), .system_bus_ready_in(ready),
		.src_a_in(src_a), .src_b_in(src_b), .ret_addr_in(ret), .busy_out(busy),
		.done_out(done), .flush_out(flush), .abort_out(abort), .illegal_out(illegal),
		.r12_test_out(r12), .link_wr_out(link_wr), .link_data_out(link_data),
		.dbg_ret_wr_out(dbg_wr), .dbg_ret_data_out(dbg_data), .rv_wr_out(rv_wr),
		.rv_data_out(rv_data), .mem_wr_out(mem_wr), .mem_data_out(mem_data),
		.mem_size_out(mem_size), .mem_word_out(mem_word));

	sbci_mem_model slave (.clk_in(clk), .rst_b_in(rst_b), .mem_word_in(mem_word),
		.wait_cycles_in(waits), .ready_out(ready));

	////////////////////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	// Issue one instruction at a falling edge and follow it to done or abort
	task automatic go(input int exp_lat);
		int k;
		int nb;
		seen = 9'h000;
		n_wr = 0;
		nb = 0;
		valid = 1'b1;
		@(posedge clk);
		@(negedge clk);
		valid = 1'b0;
		for (k = 1; k <= 60; k++) begin
			if (k == irq_at) begin
				irq = 1'b1;
			end
			seen = seen | {done, mem_word, illegal, abort, r12, rv_wr, dbg_wr, link_wr, flush};
			if (busy === 1'b1) begin
				nb++;
			end
			if (mem_wr === 1'b1) begin
				n_wr++;
				if (n_wr == 1) begin
					first_data = mem_data;
				end
				last_data = mem_data;
			end
			if (done === 1'b1 || abort === 1'b1) begin
				break;
			end
			@(negedge clk);
		end
		irq = 1'b0;
		irq_at = 0;
		if (k > 60) begin
			miscompares++;
			final_report();
		end
		check("latency", k, exp_lat);
		check("busy cycles", nb, exp_lat - 1);
		// One idle edge so the next request never reuses this time step
		@(negedge clk);
	endtask

	////////////////////////////////////////////////////////////////////////////
	task automatic t_simple();
		sbci_op_t ops[14] = '{SBCI_OP_LD_SP, SBCI_OP_ST_SP, SBCI_OP_BYTE_STORE,
			SBCI_OP_HALF_STORE, SBCI_OP_WORD_STORE, SBCI_OP_BYTE_STORE, SBCI_OP_WORD_STORE,
			SBCI_OP_DOUBLE_STORE, SBCI_OP_DOUBLE_STORE, SBCI_OP_COMBINE, SBCI_OP_COMBINE,
			SBCI_OP_SWAP_STORE, SBCI_OP_DOUBLE_STORE, SBCI_OP_DOUBLE_STORE};
		sbci_mode_t md[14] = '{SBCI_MODE_DISP, SBCI_MODE_DISP, SBCI_MODE_POSTINC,
			SBCI_MODE_PREDEC, SBCI_MODE_DISP, SBCI_MODE_INDEXED, SBCI_MODE_INDEXED,
			SBCI_MODE_DISP, SBCI_MODE_INDEXED, SBCI_MODE_DISP, SBCI_MODE_INDEXED,
			SBCI_MODE_DISP, SBCI_MODE_PLAIN, SBCI_MODE_PREDEC};
		int lat[14] = '{1, 1, 1, 1, 1, 2, 2, 2, 3, 2, 2, 1, 2, 2};
		for (int i = 0; i < 14; i++) begin
			op = ops[i];
			mode = md[i];
			go(lat[i]);
		end
	endtask

	task automatic t_data();
		mode = SBCI_MODE_DISP;
		op = SBCI_OP_DOUBLE_STORE;
		go(2);
		check("double writes", n_wr, 2);
		check("double second word", last_data, src_b);
		check("double first word", first_data, src_a);
		op = SBCI_OP_COMBINE;
		go(2);
		check("combine data", last_data, {src_a[15:0], src_b[15:0]});
		op = SBCI_OP_SWAP_STORE;
		size = SBCI_SZ_HALF;
		go(1);
		check("swap half", last_data, {16'h0000, src_a[7:0], src_a[15:8]});
		check("swap half size", mem_size, SBCI_SZ_HALF);
		size = SBCI_SZ_WORD;
		go(1);
		check("swap word", last_data, {src_a[7:0], src_a[15:8], src_a[23:16], src_a[31:24]});
	endtask

	task automatic t_cond();
		rev = 4'h2;
		op = SBCI_OP_COND_STORE;
		cond = 1'b0;
		go(1);
		check("cond false writes", n_wr, 0);
		cond = 1'b1;
		size = SBCI_SZ_BYTE;
		go(1);
		check("cond true writes", n_wr, 1);
		check("cond byte size", mem_size, SBCI_SZ_BYTE);
		size = SBCI_SZ_WORD;
		rev = 4'h1;
		go(1);
		check("old revision refused", {n_wr[3:0], seen[6]}, 5'h01);
		rev = 4'h2;
		op = SBCI_OP_STCOND;
		go(3);
		cond = 1'b0;
		go(2);
	endtask

	task automatic t_multi();
		sbci_op_t ops[15] = '{SBCI_OP_LDM, SBCI_OP_LDM, SBCI_OP_LDM, SBCI_OP_LDM, SBCI_OP_LDM,
			SBCI_OP_LDMTS, SBCI_OP_LDMTS, SBCI_OP_LDMTS, SBCI_OP_POPM, SBCI_OP_POPM,
			SBCI_OP_PUSHM, SBCI_OP_PUSHM, SBCI_OP_STM, SBCI_OP_STM, SBCI_OP_STMTS};
		// Packed as {pc, writeback, bus}
		logic [2:0] f[15] = '{3'h0, 3'h4, 3'h2, 3'h5, 3'h3, 3'h0, 3'h2, 3'h1, 3'h4, 3'h1,
			3'h0, 3'h1, 3'h0, 3'h3, 3'h2};
		int lat[15] = '{4, 5, 5, 8, 7, 4, 5, 7, 5, 7, 5, 6, 4, 6, 5};
		n = 5'h03;
		for (int i = 0; i < 15; i++) begin
			op = ops[i];
			{p, wb, sys} = f[i];
			go(lat[i]);
			check("word accesses", seen[7], 1'b1);
			check("pc flush", seen[0], p);
			check("return value test", seen[4], p);
		end
		{p, wb, sys} = 3'h0;
		n = 5'h10;
		op = SBCI_OP_PUSHM;
		go(18);
	endtask

	task automatic t_wait();
		sys = 1'b1;
		n = 5'h02;
		waits = 4'h3;
		op = SBCI_OP_PUSHM;
		go(8);
		waits = 4'h2;
		op = SBCI_OP_LDM;
		go(7);
		waits = 4'h0;
		sys = 1'b0;
	endtask

	task automatic t_abort();
		n = 5'h05;
		op = SBCI_OP_PUSHM;
		irq_at = 2;
		go(3);
		check("abort mid run", {seen[5], seen[8]}, 2'h2);
		irq = 1'b1;
		go(1);
		check("abort at issue", {seen[5], seen[8]}, 2'h2);
	endtask

	task automatic t_branch();
		sbci_op_t ops[5] = '{SBCI_OP_BRANCH, SBCI_OP_BRANCH, SBCI_OP_RJMP, SBCI_OP_RET,
			SBCI_OP_RET};
		logic c[5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
		int lat[5] = '{3, 1, 3, 3, 1};
		for (int i = 0; i < 5; i++) begin
			op = ops[i];
			cond = c[i];
			go(lat[i]);
			check("branch flush", seen[0], lat[i] == 3);
		end
		check("return moves and tests", seen[4:3], 2'h3);
		check("return value data", rv_data, src_a);
	endtask

	task automatic t_call();
		rev = 4'h3;
		op = SBCI_OP_CALL;
		go(4);
		check("call link written", seen[1:0], 2'h3);
		check("call link data", link_data, ret);
		op = SBCI_OP_SCALL;
		go(6);
		op = SBCI_OP_SSCALL;
		go(5);
		rev = 4'h2;
		go(1);
		check("secure call refused", seen[6], 1'b1);
		op = SBCI_OP_BKPT;
		dbg = 1'b0;
		ret = 32'h00002A40;
		go(1);
		check("bkpt as nop", seen[2:0], 3'h0);
		dbg = 1'b1;
		go(3);
		check("bkpt strobes", seen[2:1], 2'h2);
		check("bkpt saves", dbg_data, ret);
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(negedge clk);
		rst_b = 1'b1;
		@(negedge clk);
		t_simple();
		t_data();
		t_cond();
		t_multi();
		t_wait();
		t_abort();
		t_branch();
		t_call();
		final_report();
	end
endmodule
